// ==== rsw_top.sv ====
// reset supervisor and windowed watchdog driven by setup words
`timescale 1ns/1ps
`default_nettype none
module rsw_top
  import rsw_pkg::*;
#(
  parameter logic [23:0] PU_64_CYC = 24'(rsw_pkg::RSW_PU_64_CYC), // 64 ms count
  parameter logic [23:0] PU_16_CYC = 24'(rsw_pkg::RSW_PU_16_CYC), // 16 ms count
  parameter logic [23:0] PU_1_CYC = 24'(rsw_pkg::RSW_PU_1_CYC) // 1 ms count
)(
  input wire logic mclk_i, // 200 MHz clock
  input wire logic rst_n_i, // sync reset, low
  input wire logic wb_cyc_i, // bus cycle
  input wire logic wb_stb_i, // bus strobe
  input wire logic wb_we_i, // write
  input wire logic [31:0] wb_adr_i, // byte address
  input wire logic [3:0] wb_sel_i, // byte lanes
  input wire logic [31:0] wb_dat_i, // write data
  output logic [31:0] wb_dat_o, // read data
  output logic wb_ack_o, // acknowledge
  input wire logic [13:0] supervisor_word_i, // supervisor_setup_word
  input wire logic [13:0] watchdog_word_i, // watchdog_setup_word
  input wire logic low_voltage_program_enable_i, // lvp setting
  input wire logic sleep_i, // device asleep
  input wire logic low_freq_osc_tick_i, // lf osc tick
  input wire logic mid_freq_osc_tick_i, // mf osc tick
  input wire logic secondary_osc_tick_i, // secondary osc tick
  input wire logic external_reset_pin_n_i, // shared pin level
  output logic brownout_reset_en_o, // brownout armed
  output logic brownout_trip_voltage_low_o, // low threshold
  output logic lowpower_brownout_en_o, // low-power brownout on
  output logic powerup_delay_done_o, // power-up delay over
  output logic reset_pin_is_reset_o, // pin works as reset
  output logic ext_reset_req_o, // reset from pin
  output logic shared_port_pin_o, // pin as port data
  output logic wdog_reset_o, // watchdog reset pulse
  output logic irq_o // interrupt level
);

  // ****************************************
  // captured setup words
  // ****************************************
  logic [13:0] sup_ff; // supervisor word
  logic [13:0] wdw_ff; // watchdog word
  logic lvp_ff; // low-voltage programming

  // words are latched while reset is held, stable after it
  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      sup_ff <= supervisor_word_i;
      wdw_ff <= watchdog_word_i;
      lvp_ff <= low_voltage_program_enable_i;
    end
  end

  logic [1:0] brownout_enable_mode; // brownout mode
  logic [1:0] powerup_delay_select; // delay code
  logic [2:0] wdog_clock_select; // clock code
  logic [2:0] wdog_window_select; // window code
  logic [1:0] wdog_operating_mode; // watchdog mode
  logic [4:0] wdog_period_select; // period code
  assign brownout_enable_mode = sup_ff[RSW_SUP_BROWNOUT_ENABLE_MODE_LSB +: 2];
  assign powerup_delay_select = sup_ff[RSW_SUP_POWERUP_DELAY_SELECT_LSB +: 2];
  assign wdog_clock_select = wdw_ff[RSW_WD_CCS_LSB +: 3];
  assign wdog_window_select = wdw_ff[RSW_WD_CWS_LSB +: 3];
  assign wdog_operating_mode = wdw_ff[RSW_WD_WDOG_OPERATING_MODE_LSB +: 2];
  assign wdog_period_select = wdw_ff[RSW_WD_CPS_LSB +: 5];

  // ****************************************
  // helper functions
  // ****************************************
  // byte-lane merge of write data onto old word
  function automatic logic [31:0] rsw_merge(input logic [31:0] old_w,
                                            input logic [31:0] new_w,
                                            input logic [3:0] sel);
    logic [31:0] res;
    res = old_w;
    for (int i = 0; i < 4; i++)
    begin
      if (sel[i])
      begin
        res[i*8 +: 8] = new_w[i*8 +: 8];
      end
    end
    return res;
  endfunction : rsw_merge

  // last count of a period of 2^(ps+5) ticks
  function automatic logic [22:0] rsw_last(input logic [4:0] ps);
    return 23'h7fffff >> (RSW_CPS_MAX_FIXED - ps);
  endfunction : rsw_last

  // count still inside the closed part of the window
  function automatic logic rsw_closed(input logic [22:0] cnt,
                                      input logic [4:0] ps,
                                      input logic [2:0] win);
    logic [2:0] eighths;
    logic [25:0] lim;
    eighths = (win >= RSW_CWS_OPEN_MIN) ? 3'h0 : 3'(RSW_CWS_CLOSED_TOP - win);
    lim = {23'h0, eighths} << (ps + RSW_EIGHTH_SHIFT);
    return {3'h0, cnt} < lim;
  endfunction : rsw_closed

  // ****************************************
  // wishbone slave
  // ****************************************
  logic ack_ff; // ack register
  logic [31:0] dat_ff; // read data register
  logic req; // new request
  logic wr; // write request
  logic [31:0] wdat; // merged write word
  logic [31:0] ctrl_rd; // control readback
  logic [31:0] rd_mux; // read selection
  logic soft_brownout_enable_ff; // soft_brownout_enable
  logic sen_ff; // wdog_soft_enable
  logic clr_ff; // clear strobe
  logic [1:0] csel_ff; // runtime clock select
  logic [2:0] win_ff; // runtime window
  logic [4:0] rt_ps_ff; // wdog_runtime_period
  logic [1:0] stat_ff; // sticky events
  logic [1:0] mask_ff; // event mask
  logic [1:0] events; // events this cycle
  logic irq_ff; // interrupt register

  assign req = wb_cyc_i & wb_stb_i & ~ack_ff;
  assign wr = req & wb_we_i;

  // control word image for reads and merging
  always_comb
  begin
    ctrl_rd = 32'h0;
    ctrl_rd[RSW_CTRL_SOFT_BROWNOUT_ENABLE_BIT] = soft_brownout_enable_ff;
    ctrl_rd[RSW_CTRL_SEN_BIT] = sen_ff;
    ctrl_rd[RSW_CTRL_CSEL_LSB +: 2] = csel_ff;
    ctrl_rd[RSW_CTRL_WIN_LSB +: 3] = win_ff;
    ctrl_rd[RSW_CTRL_PS_LSB +: 5] = rt_ps_ff;
  end

  // read multiplexer, unmapped reads as zero
  always_comb
  begin
    case (wb_adr_i)
      RSW_CTRL_ADR: rd_mux = ctrl_rd;
      RSW_STAT_ADR: rd_mux = {30'h0, stat_ff};
      RSW_MASK_ADR: rd_mux = {30'h0, mask_ff};
      RSW_SUP_WORD_ADR: rd_mux = {18'h0, sup_ff};
      RSW_WDOG_WORD_ADR: rd_mux = {18'h0, wdw_ff};
      default: rd_mux = 32'h0;
    endcase
  end

  assign wdat = rsw_merge(ctrl_rd, wb_dat_i, wb_sel_i);

  // ack one cycle after request, dropped the next
  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      ack_ff <= 1'b0;
      dat_ff <= 32'h0;
    end
    else
    begin
      ack_ff <= req;
      dat_ff <= (req & ~wb_we_i) ? rd_mux : 32'h0;
    end
  end

  // control register writes
  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      soft_brownout_enable_ff <= 1'b0;
      sen_ff <= 1'b0;
      csel_ff <= RSW_CTRL_CSEL_RST;
      win_ff <= RSW_CTRL_WIN_RST;
      rt_ps_ff <= RSW_CTRL_PS_RST;
      clr_ff <= 1'b0;
    end
    else
    begin
      clr_ff <= 1'b0; // strobe lasts one cycle
      if (wr && wb_adr_i == RSW_CTRL_ADR)
      begin
        soft_brownout_enable_ff <= wdat[RSW_CTRL_SOFT_BROWNOUT_ENABLE_BIT];
        sen_ff <= wdat[RSW_CTRL_SEN_BIT];
        clr_ff <= wb_sel_i[0] & wb_dat_i[RSW_CTRL_CLR_BIT];
        csel_ff <= wdat[RSW_CTRL_CSEL_LSB +: 2];
        // window changeable only with an open window code
        if (wdog_window_select >= RSW_CWS_OPEN_MIN)
        begin
          win_ff <= wdat[RSW_CTRL_WIN_LSB +: 3];
        end
        // period changeable only under the runtime period code
        if (wdog_period_select == RSW_CPS_SOFT)
        begin
          rt_ps_ff <= wdat[RSW_CTRL_PS_LSB +: 5];
        end
      end
    end
  end

  // sticky status, write one clears, new event wins
  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      stat_ff <= 2'h0;
      mask_ff <= 2'h0;
      irq_ff <= 1'b0;
    end
    else
    begin
      if (wr && wb_adr_i == RSW_STAT_ADR && wb_sel_i[0])
      begin
        stat_ff <= (stat_ff & ~wb_dat_i[1:0]) | events;
      end
      else
      begin
        stat_ff <= stat_ff | events;
      end
      if (wr && wb_adr_i == RSW_MASK_ADR && wb_sel_i[0])
      begin
        mask_ff <= wb_dat_i[1:0];
      end
      irq_ff <= |(stat_ff & mask_ff);
    end
  end

  // ****************************************
  // supervisor decode
  // ****************************************
  logic bor_en_ff; // brownout armed
  logic level_ff; // low threshold chosen
  logic lpbor_ff; // low-power brownout
  logic pin_rst_ff; // pin is reset input
  logic ext_req_ff; // pin reset request
  logic port_ff; // pin port data

  // brownout enable, threshold and pin function
  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      bor_en_ff <= 1'b0;
      level_ff <= 1'b0;
      lpbor_ff <= 1'b0;
      pin_rst_ff <= 1'b0;
      ext_req_ff <= 1'b0;
      port_ff <= 1'b0;
    end
    else
    begin
      case (brownout_enable_mode)
        RSW_MODE_ALWAYS: bor_en_ff <= 1'b1;
        RSW_MODE_AWAKE: bor_en_ff <= ~sleep_i;
        RSW_MODE_SOFT: bor_en_ff <= soft_brownout_enable_ff;
        default: bor_en_ff <= 1'b0;
      endcase
      level_ff <= sup_ff[RSW_SUP_BROWNOUT_LEVEL_SELECT_BIT];
      lpbor_ff <= ~sup_ff[RSW_SUP_LPBOR_BIT];
      pin_rst_ff <= lvp_ff | sup_ff[RSW_SUP_RESET_PIN_ENABLE_BIT];
      ext_req_ff <= (lvp_ff | sup_ff[RSW_SUP_RESET_PIN_ENABLE_BIT]) & ~external_reset_pin_n_i;
      port_ff <= ~(lvp_ff | sup_ff[RSW_SUP_RESET_PIN_ENABLE_BIT]) & external_reset_pin_n_i;
    end
  end

  // ****************************************
  // power-up delay timer
  // ****************************************
  rsw_pu_state_t pu_state_ff; // timer state
  logic [23:0] pu_cnt_ff; // elapsed cycles
  logic [23:0] pu_lim; // selected delay

  // delay length from the setup field
  always_comb
  begin
    case (powerup_delay_select)
      RSW_POWERUP_DELAY_TIMER_64: pu_lim = PU_64_CYC;
      RSW_POWERUP_DELAY_TIMER_16: pu_lim = PU_16_CYC;
      RSW_POWERUP_DELAY_TIMER_OFF: pu_lim = 24'h0;
      default: pu_lim = PU_1_CYC;
    endcase
  end

  // counts from reset release until the delay ends
  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      pu_state_ff <= RSW_PU_WAIT;
      pu_cnt_ff <= 24'h0;
    end
    else
    begin
      case (pu_state_ff)
        RSW_PU_WAIT:
        begin
          pu_cnt_ff <= pu_cnt_ff + 24'h1;
          if (powerup_delay_select == RSW_POWERUP_DELAY_TIMER_OFF || pu_cnt_ff + 24'h1 >= pu_lim)
          begin
            pu_state_ff <= RSW_PU_DONE;
          end
        end
        RSW_PU_DONE: pu_state_ff <= RSW_PU_DONE;
        default: pu_state_ff <= RSW_PU_WAIT;
      endcase
    end
  end

  // ****************************************
  // watchdog
  // ****************************************
  logic [2:0] src; // effective clock code
  logic tick; // selected tick
  logic [4:0] ps_eff; // effective period code
  logic [2:0] win_eff; // effective window code
  logic run; // watchdog running
  logic [22:0] wd_cnt_ff; // tick counter
  logic expire; // period ran out
  logic winviol; // clear while closed
  logic wd_rst_ff; // reset pulse register

  // clock source, period, window and mode decode
  always_comb
  begin
    src = (wdog_clock_select == RSW_CCS_SOFT) ? {1'b0, csel_ff} : wdog_clock_select;
    case (src)
      RSW_CCS_LF: tick = low_freq_osc_tick_i;
      RSW_CCS_MF: tick = mid_freq_osc_tick_i;
      RSW_CCS_SECONDARY_OSC: tick = secondary_osc_tick_i;
      default: tick = 1'b0; // reserved codes count nothing
    endcase
    if (wdog_period_select <= RSW_CPS_MAX_FIXED)
    begin
      ps_eff = wdog_period_select;
    end
    else if (wdog_period_select == RSW_CPS_SOFT)
    begin
      ps_eff = (rt_ps_ff > RSW_CPS_MAX_FIXED) ? RSW_CPS_MAX_FIXED : rt_ps_ff;
    end
    else
    begin
      ps_eff = RSW_CPS_MIN;
    end
    win_eff = (wdog_window_select >= RSW_CWS_OPEN_MIN) ? win_ff : wdog_window_select;
    case (wdog_operating_mode)
      RSW_MODE_ALWAYS: run = 1'b1;
      RSW_MODE_AWAKE: run = ~sleep_i;
      RSW_MODE_SOFT: run = sen_ff;
      default: run = 1'b0;
    endcase
  end

  assign expire = run & tick & (wd_cnt_ff == rsw_last(ps_eff));
  assign winviol = run & clr_ff & rsw_closed(wd_cnt_ff, ps_eff, win_eff);
  assign events = {winviol, expire};

  // prescaled tick counter, restarts on clear or expiry
  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      wd_cnt_ff <= 23'h0;
      wd_rst_ff <= 1'b0;
    end
    else
    begin
      wd_rst_ff <= expire | winviol;
      if (!run || clr_ff || expire)
      begin
        wd_cnt_ff <= 23'h0;
      end
      else if (tick)
      begin
        wd_cnt_ff <= wd_cnt_ff + 23'h1;
      end
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign wb_dat_o = dat_ff;
  assign wb_ack_o = ack_ff;
  assign brownout_reset_en_o = bor_en_ff;
  assign brownout_trip_voltage_low_o = level_ff;
  assign lowpower_brownout_en_o = lpbor_ff;
  assign powerup_delay_done_o = (pu_state_ff == RSW_PU_DONE);
  assign reset_pin_is_reset_o = pin_rst_ff;
  assign ext_reset_req_o = ext_req_ff;
  assign shared_port_pin_o = port_ff;
  assign wdog_reset_o = wd_rst_ff;
  assign irq_o = irq_ff;

  // ****************************************
  // assertions
  // ****************************************
  // rst_n_i in the antecedent keeps the release edge out: outputs still hold reset values
  property p_bor_awake;
    @(posedge mclk_i) disable iff (!rst_n_i)
      (rst_n_i && brownout_enable_mode == RSW_MODE_AWAKE)
        |=> (brownout_reset_en_o == !$past(sleep_i));
  endproperty
  a_bor_awake: assert property (p_bor_awake) else $error("brownout awake mode wrong");

  property p_bor_soft;
    @(posedge mclk_i) disable iff (!rst_n_i)
      (brownout_enable_mode == RSW_MODE_SOFT) |=> (brownout_reset_en_o == $past(soft_brownout_enable_ff));
  endproperty
  a_bor_soft: assert property (p_bor_soft) else $error("brownout soft mode wrong");

  property p_level;
    @(posedge mclk_i) disable iff (!rst_n_i)
      rst_n_i |=> (brownout_trip_voltage_low_o == $past(sup_ff[RSW_SUP_BROWNOUT_LEVEL_SELECT_BIT]));
  endproperty
  a_level: assert property (p_level) else $error("trip level wrong");

  property p_lpbor;
    @(posedge mclk_i) disable iff (!rst_n_i)
      sup_ff[RSW_SUP_LPBOR_BIT] |=> !lowpower_brownout_en_o;
  endproperty
  a_lpbor: assert property (p_lpbor) else $error("low-power brownout on");

  property p_pin_lvp;
    @(posedge mclk_i) disable iff (!rst_n_i)
      (rst_n_i && lvp_ff && !external_reset_pin_n_i)
        |=> (reset_pin_is_reset_o && ext_reset_req_o);
  endproperty
  a_pin_lvp: assert property (p_pin_lvp) else $error("pin not reset under lvp");

  property p_wd_off;
    @(posedge mclk_i) disable iff (!rst_n_i)
      (wdog_operating_mode == 2'h0) |=> !wdog_reset_o;
  endproperty
  a_wd_off: assert property (p_wd_off) else $error("disabled watchdog reset");

  property p_ps_lock;
    @(posedge mclk_i) disable iff (!rst_n_i)
      (wdog_period_select != RSW_CPS_SOFT) |=> $stable(rt_ps_ff);
  endproperty
  a_ps_lock: assert property (p_ps_lock) else $error("fixed period changed");

  property p_winviol;
    @(posedge mclk_i) disable iff (!rst_n_i)
      (run && clr_ff && rsw_closed(wd_cnt_ff, ps_eff, win_eff))
        |=> (wdog_reset_o && stat_ff[RSW_STAT_WINVIOL_BIT] && wd_cnt_ff == 23'h0);
  endproperty
  a_winviol: assert property (p_winviol) else $error("early clear missed");

endmodule : rsw_top
`default_nettype wire

// ==== rsw_pkg.sv ====
// constants shared by the reset supervisor and watchdog configuration block
package rsw_pkg;

  // ****************************************
  // register map (byte addresses)
  // ****************************************
  localparam logic [31:0] RSW_CTRL_ADR = 32'h0000_0000; // control word
  localparam logic [31:0] RSW_STAT_ADR = 32'h0000_0004; // sticky events
  localparam logic [31:0] RSW_MASK_ADR = 32'h0000_0008; // event mask
  localparam logic [31:0] RSW_SUP_WORD_ADR = 32'h0000_000c; // supervisor_setup_word
  localparam logic [31:0] RSW_WDOG_WORD_IDX = 32'h0000_8009; // watchdog_setup_word index
  localparam logic [31:0] RSW_WDOG_WORD_ADR = RSW_WDOG_WORD_IDX << 2; // its byte address

  // ****************************************
  // supervisor_setup_word fields
  // ****************************************
  localparam int RSW_SUP_BROWNOUT_LEVEL_SELECT_BIT = 9; // brownout_level_select
  localparam int RSW_SUP_BROWNOUT_ENABLE_MODE_LSB = 6; // brownout_enable_mode
  localparam int RSW_SUP_LPBOR_BIT = 5; // lowpower_brownout_enable_n
  localparam int RSW_SUP_POWERUP_DELAY_SELECT_LSB = 1; // powerup_delay_select
  localparam int RSW_SUP_RESET_PIN_ENABLE_BIT = 0; // reset_pin_enable

  // ****************************************
  // watchdog_setup_word fields
  // ****************************************
  localparam int RSW_WD_CCS_LSB = 11; // wdog_clock_select
  localparam int RSW_WD_CWS_LSB = 8; // wdog_window_select
  localparam int RSW_WD_WDOG_OPERATING_MODE_LSB = 5; // wdog_operating_mode
  localparam int RSW_WD_CPS_LSB = 0; // wdog_period_select

  // ****************************************
  // control and status layout, reset values
  // ****************************************
  localparam int RSW_CTRL_SOFT_BROWNOUT_ENABLE_BIT = 0; // soft_brownout_enable
  localparam int RSW_CTRL_SEN_BIT = 1; // wdog_soft_enable
  localparam int RSW_CTRL_CLR_BIT = 2; // watchdog clear strobe
  localparam int RSW_CTRL_CSEL_LSB = 4; // runtime clock select, 2 bits
  localparam int RSW_CTRL_WIN_LSB = 8; // runtime window, 3 bits
  localparam int RSW_CTRL_PS_LSB = 16; // wdog_runtime_period, 5 bits
  localparam logic [4:0] RSW_CTRL_PS_RST = 5'h0b; // 1:65536 at power-on
  localparam logic [2:0] RSW_CTRL_WIN_RST = 3'h7; // fully open
  localparam logic [1:0] RSW_CTRL_CSEL_RST = 2'h0; // low-frequency osc
  localparam int RSW_STAT_EXPIRE_BIT = 0; // timeout event
  localparam int RSW_STAT_WINVIOL_BIT = 1; // early clear event

  // ****************************************
  // field codes
  // ****************************************
  localparam logic [1:0] RSW_MODE_ALWAYS = 2'h3; // on even in sleep
  localparam logic [1:0] RSW_MODE_AWAKE = 2'h2; // on while awake
  localparam logic [1:0] RSW_MODE_SOFT = 2'h1; // software bit decides
  localparam logic [1:0] RSW_POWERUP_DELAY_TIMER_OFF = 2'h3; // no power-up delay
  localparam logic [1:0] RSW_POWERUP_DELAY_TIMER_64 = 2'h2; // 64 ms
  localparam logic [1:0] RSW_POWERUP_DELAY_TIMER_16 = 2'h1; // 16 ms
  localparam logic [2:0] RSW_CCS_LF = 3'h0; // low_freq_internal_osc
  localparam logic [2:0] RSW_CCS_MF = 3'h1; // mid_freq_internal_osc
  localparam logic [2:0] RSW_CCS_SECONDARY_OSC = 3'h2; // secondary_osc
  localparam logic [2:0] RSW_CCS_SOFT = 3'h7; // runtime selection
  localparam logic [2:0] RSW_CWS_OPEN_MIN = 3'h6; // 110/111 open window
  localparam logic [2:0] RSW_CWS_CLOSED_TOP = 3'h7; // eighths = 7 - code
  localparam logic [4:0] RSW_CPS_MAX_FIXED = 5'h12; // 1:8388608
  localparam logic [4:0] RSW_CPS_SOFT = 5'h1f; // runtime period
  localparam logic [4:0] RSW_CPS_MIN = 5'h00; // 1:32
  localparam logic [4:0] RSW_EIGHTH_SHIFT = 5'h02; // period/8 = 2^(ps+2)

  // ****************************************
  // timing
  // ****************************************
  localparam int RSW_CLK_KHZ = 200000; // 200 MHz clock
  localparam int RSW_PU_64_MS = 64; // long delay
  localparam int RSW_PU_16_MS = 16; // medium delay
  localparam int RSW_PU_1_MS = 1; // short delay
  localparam int RSW_PU_64_CYC = RSW_PU_64_MS * RSW_CLK_KHZ; // cycles
  localparam int RSW_PU_16_CYC = RSW_PU_16_MS * RSW_CLK_KHZ; // cycles
  localparam int RSW_PU_1_CYC = RSW_PU_1_MS * RSW_CLK_KHZ; // cycles

  // power-up timer states
  typedef enum logic {RSW_PU_WAIT, RSW_PU_DONE} rsw_pu_state_t;

endpackage : rsw_pkg

// ==== rsw_top_tb_top.sv ====
// self-checking bench for the reset supervisor and watchdog setup block
`timescale 1ns/1ps
`default_nettype none
module rsw_top_tb_top;
  import rsw_pkg::*;
  // ****
  // stimulus and observed signals
  // ****
  logic mclk, rst_n, cyc, stb, we, lf, mf, so, sleep, low_voltage_program_enable, pin; // driven inputs
  logic [31:0] adr, dat; // bus request
  logic [3:0] sel; // byte lanes
  logic [13:0] sup, wd, s; // setup words
  wire logic [31:0] rdat; // read data
  wire logic ack, bo_en, bo_low, lp_en, pu_done, pin_rst, ext_req, port_pin, wd_rst, irq;
  int errors, num_checks, seed; // counters, random seed
  logic [31:0] expq[$]; // expected read data, oldest first
  rsw_top #(.PU_64_CYC(24'd64), .PU_16_CYC(24'd16), .PU_1_CYC(24'd8)) rsw_top_i (
    .mclk_i(mclk), .rst_n_i(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .supervisor_word_i(sup), .watchdog_word_i(wd), .low_voltage_program_enable_i(low_voltage_program_enable),
    .sleep_i(sleep), .low_freq_osc_tick_i(lf), .mid_freq_osc_tick_i(mf),
    .secondary_osc_tick_i(so), .external_reset_pin_n_i(pin),
    .brownout_reset_en_o(bo_en), .brownout_trip_voltage_low_o(bo_low),
    .lowpower_brownout_en_o(lp_en), .powerup_delay_done_o(pu_done),
    .reset_pin_is_reset_o(pin_rst), .ext_reset_req_o(ext_req),
    .shared_port_pin_o(port_pin), .wdog_reset_o(wd_rst), .irq_o(irq));
  // ****
  // helpers
  // ****
  // compare and count
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e)
    begin
      errors++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // one-bit wrapper
  task automatic chkb(input string nm, input logic e, input logic g);
    chk(nm, {31'b0, e}, {31'b0, g});
  endtask : chkb
  // classic cycle, held until ack is sampled high
  task automatic wb(input logic w, input logic [31:0] a, input logic [31:0] d,
                    input logic [31:0] e);
    @(posedge mclk);
    {cyc, stb, we, adr, dat, sel} <= {2'b11, w, a, d, 4'hf};
    if (!w)
      expq.push_back(e);
    do @(posedge mclk); while (ack !== 1'b1);
    {cyc, stb} <= 2'b00;
  endtask : wb
  // reset with setup words presented
  task automatic boot(input logic [13:0] sw, input logic [13:0] ww, input logic l);
    @(posedge mclk);
    {rst_n, sup, wd, low_voltage_program_enable} <= {1'b0, sw, ww, l};
    repeat (12) @(posedge mclk);
    rst_n <= 1'b1;
  endtask : boot
  // single-cycle ticks on the chosen oscillators {so, mf, lf}
  task automatic tick(input int n, input logic [2:0] w);
    repeat (n)
    begin
      @(posedge mclk);
      {so, mf, lf} <= w;
      @(posedge mclk);
      {so, mf, lf} <= 3'b000;
    end
  endtask : tick
  // bounded wait for the watchdog reset pulse
  task automatic wait_rst;
    int n;
    n = 0;
    while (wd_rst !== 1'b1 && n < 8)
    begin
      @(posedge mclk);
      n++;
    end
  endtask : wait_rst
  // verdict, single exit point
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : end_of_test
  // ****
  // clock, read monitor, watchdog
  // ****
  initial
  begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  // read data is compared with the oldest note
  always @(posedge mclk)
    if (ack === 1'b1 && we === 1'b0 && expq.size() > 0)
      chk("rdat", expq.pop_front(), rdat);
  // hang guard, far beyond the expected run
  initial
  begin
    repeat (20000) @(posedge mclk);
    errors++;
    end_of_test();
  end
  // ****
  // main sequence
  // ****
  initial
  begin
    {rst_n, cyc, stb, we, lf, mf, so, sleep, low_voltage_program_enable, pin} = '0;
    {adr, dat, sel, sup, wd, s} = '0;
    {errors, num_checks} = '0;
    seed = 32'h7025;
    // every enable, delay and pin mode code, random filler bits
    for (int i = 0; i < 4; i++)
    begin
      s = 14'($random(seed));
      s[7:6] = i[1:0];
      s[2:1] = i[1:0];
      s[0] = i[0];
      s[9] = i[1] ^ i[0];
      s[5] = i[1];
      s[13] = 1'b1;
      boot(s, (i == 3) ? 14'h001f : 14'h0000, i[1]);
      pin <= 1'($random(seed));
      sleep <= 1'($random(seed));
      repeat (3) @(posedge mclk);
      chkb("pu_done", i == 3, pu_done);
      chkb("bo_low", s[9], bo_low);
      chkb("lp_en", !s[5], lp_en);
      chkb("pin_rst", i[1] | s[0], pin_rst);
      chkb("ext_req", (i[1] | s[0]) & !pin, ext_req);
      chkb("port_pin", !(i[1] | s[0]) & pin, port_pin);
      wb(1'b1, RSW_SUP_WORD_ADR, 32'h0, 32'h0);
      wb(1'b0, RSW_SUP_WORD_ADR, 32'h0, {18'b0, s});
      wb(1'b0, 32'h0000_0100, 32'h0, 32'h0);
      wb(1'b0, RSW_CTRL_ADR, 32'h0, 32'h000b0700);
      wb(1'b1, RSW_CTRL_ADR, 32'h00050301, 32'h0);
      wb(1'b0, RSW_CTRL_ADR, 32'h0, (i == 3) ? 32'h00050701 : 32'h000b0701);
      repeat (70) @(posedge mclk);
      chkb("pu_done", 1'b1, pu_done);
      chkb("bo_en", i == 3 || (i == 2 && !sleep) || i == 1, bo_en);
      $display("decode test %0d done", i);
    end
    // expiry after exactly 32 ticks of the low-frequency clock
    boot(14'h3fff, 14'h0760, 1'b0);
    wb(1'b1, RSW_MASK_ADR, 32'h3, 32'h0);
    tick(31, 3'b001);
    wb(1'b0, RSW_STAT_ADR, 32'h0, 32'h0);
    tick(1, 3'b001);
    wait_rst();
    chkb("wd_rst", 1'b1, wd_rst);
    repeat (3) @(posedge mclk);
    chkb("irq", 1'b1, irq);
    wb(1'b0, RSW_STAT_ADR, 32'h0, 32'h1);
    wb(1'b1, RSW_STAT_ADR, 32'h1, 32'h0);
    repeat (3) @(posedge mclk);
    chkb("irq", 1'b0, irq);
    $display("expiry test done");
    // clear while the closed window is still running
    boot(14'h3fff, 14'h0060, 1'b0);
    wb(1'b1, RSW_CTRL_ADR, 32'h4, 32'h0);
    wait_rst();
    chkb("wd_rst", 1'b1, wd_rst);
    wb(1'b0, RSW_STAT_ADR, 32'h0, 32'h2);
    $display("early clear test done");
    // software clock select on the mid osc, soft mode, code 10011 fixed at 1:32
    boot(14'h3fff, 14'h3f33, 1'b0);
    wb(1'b1, RSW_CTRL_ADR, 32'h0000_0712, 32'h0);
    wb(1'b0, RSW_CTRL_ADR, 32'h0, 32'h000b0712);
    tick(40, 3'b101);
    wb(1'b0, RSW_STAT_ADR, 32'h0, 32'h0);
    tick(32, 3'b010);
    wait_rst();
    chkb("wd_rst", 1'b1, wd_rst);
    wb(1'b0, RSW_STAT_ADR, 32'h0, 32'h1);
    $display("software clock test done");
    end_of_test();
  end
endmodule : rsw_top_tb_top
`default_nettype wire
